// file: logic/evp_top.sv
// Purpose: Exception priority decoder and vector generator
// Assumes: Requests synchronous to clk; core gates its own mask flags
// Notes:   Vector answer stands one cycle after the request strobe
//
// What this block does
// - Vector base is register byte on top, zero byte below.
// - Spurious vector sits at base plus 0x80.
// - Maskable lines map to base plus 0x82 up to 0xF2.
// - One extended-mask request, vector at base plus 0xF4.
// - Software or debug entry request, vector at base plus 0xF6.
// - Unimplemented-opcode trap, vector at base plus 0xF8.
// - Reset vectors fixed at 0xFFFA to 0xFFFE, base not used.
// - Reset loads 0xFF into the vector base register.
// - In debug firmware mode the upper byte is forced to 0xFF.
// - Among pending requests the highest vector address wins.
// - Maskable line priority is fixed by its index.
// - Maskable served only if enabled, mask clear, no higher kind.
// - Non-maskable kinds always outrank maskable lines.
// - Extended-mask request is offered even during maskable service.
// - Winner is chosen when the core asks, not earlier.
// - Nothing pending at the ask gives the spurious vector.
// - In wait or stop a qualifying request raises wake.
// - Reset source picks 0xFFFE, 0xFFFC or 0xFFFA.
// - In low power, masked maskable lines do not wake.
// - Extended-mask request wakes even with its flag set.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps

module evp_top
  import evp_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [DATA_W-1:0]  reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [DATA_W-1:0]  reg_rdata,
  input  wire logic [NUM_IRQ-1:0] irq_req,
  input  wire logic               xirq_req,
  input  wire logic               software_exception,
  input  wire logic               debug_req,
  input  wire logic               trap_req,
  input  wire logic               core_imask,
  input  wire logic               core_xmask,
  input  wire logic               debug_firmware_mode,
  input  wire logic               lowpower_mode,
  input  wire logic               vec_req,
  input  wire logic               reset_vec_req,
  input  wire logic [1:0]         reset_source,
  output logic      [15:0]        vec_addr,
  output logic                    vec_valid,
  output logic                    int_pending,
  output logic                    wake
);

  logic [7:0]          vector_base_reg;
  logic [15:0]         vec_addr_reg;
  logic [15:0]         vec_addr_next;
  logic                vec_valid_reg;
  logic                int_pending_reg;
  logic                wake_reg;
  logic [DATA_W-1:0]   rdata_reg;
  evp_grant_type       grant_reg;
  evp_grant_type       grant_next;
  evp_state_type       state_reg;
  evp_state_type       state_next;

  logic [7:0]          base_now;
  logic                nonmask_pend;
  logic                xirq_ok;
  logic                irq_ok;
  logic                wake_qual;
  logic [7:0]          irq_ofs;

  evp_prio_if pif ();

  // Full 16-bit vector from an upper byte and an offset
  function automatic logic [15:0] vec_word(
    input logic [7:0] base,
    input logic [7:0] ofs
  );
    vec_word = {base, VBASE_LOW} | {8'h00, ofs};
  endfunction

  // Register read decode, used only by the read port
  function automatic logic [DATA_W-1:0] reg_view(
    input logic [ADDR_W-1:0] addr,
    input logic [7:0]        vbase,
    input logic [2:0]        grant,
    input logic              wk,
    input logic              pend
  );
    logic [DATA_W-1:0] v;
    v = '0;
    if (addr == REG_VBASE)
      v = vbase;
    else if (addr == REG_STATUS)
    begin
      v[ST_GRANT_LSB +: 3] = grant;
      v[ST_WAKE_BIT]       = wk;
      v[ST_PEND_BIT]       = pend;
    end
    reg_view = v;
  endfunction

  // Maskable lines go through the shared encoder
  assign pif.req = irq_req;

  evp_prio_enc u_enc (
    .pif (pif)
  );

  // Debug firmware overrides the programmed base
  assign base_now = debug_firmware_mode ? DEBUG_BASE
                                        : vector_base_reg;

  // Non-maskable kinds block every maskable line
  assign nonmask_pend = trap_req | software_exception | debug_req;

  // Extended-mask line is qualified only by its own flag
  assign xirq_ok = xirq_req & ~core_xmask;

  // Maskable line needs mask clear and no higher kind pending
  assign irq_ok = pif.hit & ~core_imask
                & ~nonmask_pend & ~xirq_req;

  // Even offset per line, fixed by index
  assign irq_ofs = OFS_IRQ_FIRST
                 + {1'b0, pif.idx, 1'b0};

  // Wake ignores the extended flag but honours the maskable flag
  assign wake_qual = xirq_req
                   | (pif.hit & ~core_imask);

  // Winner chosen from live requests at the ask
  always_comb
  begin
    vec_addr_next = vec_addr_reg;
    grant_next    = grant_reg;
    if (reset_vec_req)
    begin
      grant_next = G_RESET;
      unique case (reset_source)
        RS_CLKMON: vec_addr_next = VEC_RST_CLKMON;
        RS_WDOG:   vec_addr_next = VEC_RST_WDOG;
        default:   vec_addr_next = VEC_RST_MAIN;
      endcase
    end
    else if (vec_req)
    begin
      if (trap_req)
      begin
        vec_addr_next = vec_word(base_now, OFS_TRAP);
        grant_next    = G_TRAP;
      end
      else if (software_exception | debug_req)
      begin
        vec_addr_next = vec_word(base_now, OFS_SWI);
        grant_next    = G_SWI;
      end
      else if (xirq_ok)
      begin
        vec_addr_next = vec_word(base_now, OFS_XIRQ);
        grant_next    = G_XIRQ;
      end
      else if (irq_ok)
      begin
        vec_addr_next = vec_word(base_now, irq_ofs);
        grant_next    = G_IRQ;
      end
      else
      begin
        vec_addr_next = vec_word(base_now, OFS_SPURIOUS);
        grant_next    = G_SPUR;
      end
    end
  end

  // Vector answer, held until the next ask
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      vec_addr_reg <= VEC_RST_MAIN;
      grant_reg    <= G_NONE;
    end
    else
    begin
      vec_addr_reg <= vec_addr_next;
      grant_reg    <= grant_next;
    end
  end

  // One-cycle strobe beside a fresh vector
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      vec_valid_reg <= 1'b0;
    else
      vec_valid_reg <= vec_req | reset_vec_req;
  end

  // Tells the core that something would be served
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      int_pending_reg <= 1'b0;
    else
      int_pending_reg <= nonmask_pend | xirq_ok | irq_ok;
  end

  // Vector base register, writable at any time
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      vector_base_reg <= VBASE_RESET;
    else if (reg_wr && reg_addr == REG_VBASE)
      vector_base_reg <= reg_wdata;
  end

  // Read data stand one cycle, zero otherwise
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_reg <= '0;
    else if (reg_rd)
      rdata_reg <= reg_view(reg_addr, vector_base_reg, grant_reg,
                            wake_reg, int_pending_reg);
    else
      rdata_reg <= '0;
  end

  // Low-power tracking follows the core's mode level
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN:   if (lowpower_mode)  state_next = ST_SLEEP;
      ST_SLEEP: if (!lowpower_mode) state_next = ST_RUN;
      default:  state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_reg <= ST_RUN;
    else
      state_reg <= state_next;
  end

  // Wake level; needs clk running, so the gating cell
  // upstream must keep this block clocked while asleep
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wake_reg <= 1'b0;
    else
      wake_reg <= (state_reg == ST_SLEEP)
                & lowpower_mode & wake_qual;
  end

  // Outputs straight from flops
  assign vec_addr    = vec_addr_reg;
  assign vec_valid   = vec_valid_reg;
  assign int_pending = int_pending_reg;
  assign wake        = wake_reg;
  assign reg_rdata   = rdata_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_base;
    vec_req && !reset_vec_req && !debug_firmware_mode
      |=> vec_addr_reg[15:8] == $past(vector_base_reg);
  endproperty
  a_base: assert property (p_base)
    else $error("vector upper byte differs from base");

  property p_debug;
    vec_req && !reset_vec_req && debug_firmware_mode
      |=> vec_addr_reg[15:8] == DEBUG_BASE;
  endproperty
  a_debug: assert property (p_debug)
    else $error("debug base not forced");

  property p_spur;
    vec_req && !reset_vec_req && !nonmask_pend
      && !xirq_req && !pif.hit
      |=> vec_addr_reg[7:0] == OFS_SPURIOUS && vec_valid_reg;
  endproperty
  a_spur: assert property (p_spur)
    else $error("spurious vector missing");

  property p_trap;
    vec_req && !reset_vec_req && trap_req
      |=> vec_addr_reg[7:0] == OFS_TRAP;
  endproperty
  a_trap: assert property (p_trap)
    else $error("trap not granted first");

  property p_swi;
    vec_req && !reset_vec_req && !trap_req
      && (software_exception || debug_req)
      |=> vec_addr_reg[7:0] == OFS_SWI;
  endproperty
  a_swi: assert property (p_swi)
    else $error("software vector wrong");

  property p_xirq;
    vec_req && !reset_vec_req && !nonmask_pend
      && xirq_req && !core_xmask
      |=> vec_addr_reg[7:0] == OFS_XIRQ;
  endproperty
  a_xirq: assert property (p_xirq)
    else $error("extended-mask vector wrong");

  property p_masked;
    vec_req && !reset_vec_req && core_imask && !nonmask_pend
      && !xirq_req
      |=> vec_addr_reg[7:0] == OFS_SPURIOUS;
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked line was granted");

  property p_irq_range;
    vec_req && !reset_vec_req && irq_ok
      |=> vec_addr_reg[7:0] >= OFS_IRQ_FIRST
       && vec_addr_reg[7:0] <= OFS_IRQ_LAST
       && !vec_addr_reg[0];
  endproperty
  a_irq_range: assert property (p_irq_range)
    else $error("maskable vector out of range");

  property p_top_line;
    vec_req && !reset_vec_req && irq_ok && irq_req[NUM_IRQ-1]
      |=> vec_addr_reg[7:0] == OFS_IRQ_LAST;
  endproperty
  a_top_line: assert property (p_top_line)
    else $error("top line lost priority");

  property p_wdog;
    reset_vec_req && reset_source == RS_WDOG
      |=> vec_addr_reg == VEC_RST_WDOG;
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog reset vector wrong");

  property p_rst_fixed;
    reset_vec_req && reset_source == RS_MAIN
      |=> vec_addr_reg == VEC_RST_MAIN;
  endproperty
  a_rst_fixed: assert property (p_rst_fixed)
    else $error("main reset vector moved");

  property p_xwake;
    lowpower_mode && state_reg == ST_SLEEP && xirq_req
      |=> wake_reg;
  endproperty
  a_xwake: assert property (p_xwake)
    else $error("extended request did not wake");

  property p_nowake;
    core_imask && !xirq_req |=> !wake_reg;
  endproperty
  a_nowake: assert property (p_nowake)
    else $error("masked line woke the core");

  c_spur:  cover property (vec_req ##1 grant_reg == G_SPUR);
  c_irq:   cover property (vec_req ##1 grant_reg == G_IRQ);
  c_wake:  cover property (state_reg == ST_SLEEP ##1 wake_reg);
  c_reset: cover property (reset_vec_req ##1 grant_reg == G_RESET);

endmodule // evp_top

// file: logic/evp_pkg.sv
// Purpose: Shared constants and types of the exception vector prioritizer
// Assumes: 16-bit vector addresses, 8-bit register port
// Notes:   All offsets are low bytes added to the vector base

package evp_pkg;

  // Sizes
  localparam int NUM_IRQ = 57;
  localparam int IDX_W   = 6;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 4;

  // Vector base
  localparam logic [7:0] VBASE_RESET = 8'hFF;
  localparam logic [7:0] DEBUG_BASE  = 8'hFF;
  localparam logic [7:0] VBASE_LOW   = 8'h00;

  // Offsets from the vector base
  localparam logic [7:0] OFS_SPURIOUS  = 8'h80;
  localparam logic [7:0] OFS_IRQ_FIRST = 8'h82;
  localparam logic [7:0] OFS_IRQ_LAST  = 8'hF2;
  localparam logic [7:0] OFS_XIRQ      = 8'hF4;
  localparam logic [7:0] OFS_SWI       = 8'hF6;
  localparam logic [7:0] OFS_TRAP      = 8'hF8;

  // Fixed reset vectors
  localparam logic [15:0] VEC_RST_MAIN   = 16'hFFFE;
  localparam logic [15:0] VEC_RST_CLKMON = 16'hFFFC;
  localparam logic [15:0] VEC_RST_WDOG   = 16'hFFFA;

  // Register map
  localparam logic [ADDR_W-1:0] REG_VBASE  = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;

  // Status register fields
  localparam int ST_GRANT_LSB = 0;
  localparam int ST_WAKE_BIT  = 3;
  localparam int ST_PEND_BIT  = 4;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_SLEEP = 2'b10
  } evp_state_type;

  typedef enum logic [1:0] {
    RS_MAIN   = 2'h0,
    RS_CLKMON = 2'h1,
    RS_WDOG   = 2'h2
  } evp_rsrc_type;

  typedef enum logic [2:0] {
    G_NONE  = 3'h0,
    G_SPUR  = 3'h1,
    G_IRQ   = 3'h2,
    G_XIRQ  = 3'h3,
    G_SWI   = 3'h4,
    G_TRAP  = 3'h5,
    G_RESET = 3'h6
  } evp_grant_type;

endpackage

// file: logic/evp_prio_if.sv
// Purpose: Carries request lines to the encoder and the winner back
// Assumes: Purely combinational path
// Notes:   Used only between the top and the encoder
`timescale 1ns/1ps

interface evp_prio_if;
  import evp_pkg::*;
  logic [NUM_IRQ-1:0] req;
  logic               hit;
  logic [IDX_W-1:0]   idx;
  modport enc  (input req, output hit, output idx);
  modport user (output req, input hit, input idx);
endinterface

// file: logic/evp_prio_enc.sv
// Purpose: Finds the highest numbered pending maskable line
// Assumes: Line i owns offset OFS_IRQ_FIRST plus twice i
// Notes:   Higher index means higher vector address, so it wins
`timescale 1ns/1ps

module evp_prio_enc
  import evp_pkg::*;
(
  evp_prio_if.enc pif
);

  logic [NUM_IRQ:0]  hit_chain;
  logic [IDX_W-1:0]  idx_chain [NUM_IRQ:0];

  // Chain runs from the top line downward
  assign hit_chain[NUM_IRQ] = 1'b0;
  assign idx_chain[NUM_IRQ] = '0;

  genvar i;
  generate
    for (i = 0; i < NUM_IRQ; i++)
    begin : g_stage
      assign hit_chain[i] = hit_chain[i+1] | pif.req[i];
      assign idx_chain[i] = hit_chain[i+1] ? idx_chain[i+1]
                                           : IDX_W'(i);
    end
  endgenerate

  assign pif.hit = hit_chain[0];
  assign pif.idx = idx_chain[0];

endmodule // evp_prio_enc

// file: testbench/evp_core_model.sv
// Purpose: Core side of the vector port, asks and collects vectors
// Assumes: One clock, answer one cycle after the request edge
// Notes:   Asks stay one cycle long so no request is ever doubled
`timescale 1ns/1ps

module evp_core_model
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ask_vec,
  input  wire logic        ask_rst,
  input  wire logic [15:0] vec_addr,
  input  wire logic        vec_valid,
  output logic             vec_req,
  output logic             reset_vec_req,
  output logic [15:0]      got_addr,
  output logic             got_stb
);
  // Request strobes launched one edge after the bench asks
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      vec_req       <= 1'b0;
      reset_vec_req <= 1'b0;
    end
    else
    begin
      vec_req       <= ask_vec;
      reset_vec_req <= ask_rst;
    end
  end

  // Vector taken only in the single cycle it is valid
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      got_stb  <= 1'b0;
      got_addr <= 16'h0000;
    end
    else
    begin
      got_stb <= vec_valid;
      if (vec_valid)
        got_addr <= vec_addr;
    end
  end
endmodule // evp_core_model

// file: testbench/testbench.sv
// Purpose: Self-checking bench for the vector prioritizer
// Assumes: Request lines held stable around each vector ask
// Notes:   Flags f = {xirq, swi, debug, trap, imask, xmask}
`timescale 1ns/1ps

module testbench;
  import evp_pkg::*;
  logic               clk, rst, reg_wr, reg_rd, vec_req, reset_vec_req;
  logic [ADDR_W-1:0]  reg_addr;
  logic [DATA_W-1:0]  reg_wdata, reg_rdata, base;
  logic [NUM_IRQ-1:0] irq_req;
  logic               xirq_req, software_exception, debug_req, trap_req;
  logic               core_imask, core_xmask, debug_firmware_mode;
  logic               lowpower_mode, ask_vec, ask_rst, got_stb;
  logic [1:0]         reset_source;
  logic [15:0]        vec_addr, got_addr, a;
  logic               vec_valid, int_pending, wake;
  int                 failures, checks_done;

  evp_top evp_top_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_req(irq_req), .xirq_req(xirq_req),
    .software_exception(software_exception), .debug_req(debug_req),
    .trap_req(trap_req), .core_imask(core_imask), .core_xmask(core_xmask),
    .debug_firmware_mode(debug_firmware_mode),
    .lowpower_mode(lowpower_mode), .vec_req(vec_req),
    .reset_vec_req(reset_vec_req), .reset_source(reset_source),
    .vec_addr(vec_addr), .vec_valid(vec_valid),
    .int_pending(int_pending), .wake(wake));

  evp_core_model evp_core_model_i (.clk(clk), .rst(rst), .ask_vec(ask_vec),
    .ask_rst(ask_rst), .vec_addr(vec_addr), .vec_valid(vec_valid),
    .vec_req(vec_req), .reset_vec_req(reset_vec_req),
    .got_addr(got_addr), .got_stb(got_stb));

  // Free running 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Register bus, one-cycle strobes
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] ad, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Sources held until the vector is taken
  task automatic req(input logic [NUM_IRQ-1:0] i, input logic [5:0] f);
    @(posedge clk);
    irq_req <= i;
    {xirq_req, software_exception, debug_req, trap_req} <= f[5:2];
    {core_imask, core_xmask} <= f[1:0];
  endtask

  // Vector ask through the core model, bounded wait
  task automatic ask(input logic rv, output logic [15:0] v);
    int n;
    n = 0;
    @(posedge clk);
    ask_vec <= ~rv;
    ask_rst <= rv;
    @(posedge clk);
    ask_vec <= 1'b0;
    ask_rst <= 1'b0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end
    while (got_stb !== 1'b1 && n < 10);
    v = got_addr;
    if (got_stb !== 1'b1)
    begin
      failures++;
      report_and_stop();
    end
  endtask

  task automatic vchk(input logic [NUM_IRQ-1:0] i, input logic [5:0] f,
                      input logic [15:0] exp);
    req(i, f);
    ask(1'b0, a);
    check(a, exp);
  endtask

  // Reset values and the empty ask
  task automatic t_reset;
    check(vec_addr, 16'hFFFE);
    rd(REG_VBASE, base);
    check({8'h00, base}, 16'h00FF);
    vchk('0, 6'h00, 16'hFF80);
  endtask

  // Base programming, line mapping, unmapped read
  task automatic t_base;
    logic [7:0] d;
    wr(REG_VBASE, 8'h40);
    rd(REG_VBASE, d);
    check({8'h00, d}, 16'h0040);
    wr(4'hF, 8'h12);
    rd(4'hF, d);
    check({8'h00, d}, 16'h0000);
    base = 8'h40;
    vchk(57'h1, 6'h00, 16'h4082);
    vchk(57'h1 << 56, 6'h00, 16'h40F2);
  endtask

  // Ranking of every request kind
  task automatic t_prio;
    logic [NUM_IRQ-1:0] l3;
    logic [7:0]         d;
    l3 = 57'h8;
    vchk(l3 | 57'h400, 6'h00, {base, 8'h96});
    vchk(l3, 6'b100000, {base, OFS_XIRQ});
    vchk(l3, 6'b010000, {base, OFS_SWI});
    vchk(l3, 6'b001000, {base, OFS_SWI});
    vchk(l3, 6'b000100, {base, OFS_TRAP});
    vchk(l3, 6'b111100, {base, OFS_TRAP});
    vchk(l3, 6'b000010, {base, 8'h80});
    check({15'h0, int_pending}, 16'h0000);
    vchk(l3, 6'b100001, {base, 8'h80});
    vchk(l3, 6'b100010, {base, OFS_XIRQ});
    check({15'h0, int_pending}, 16'h0001);
    // Status: grant 3 (extended), pending set, no wake
    rd(REG_STATUS, d);
    check({8'h00, d}, 16'h0013);
    // Read data stand for one cycle only
    @(posedge clk);
    #1 check({8'h00, reg_rdata}, 16'h0000);
  endtask

  // Debug override and fixed reset vectors
  task automatic t_fixed;
    logic [15:0] ex [4];
    ex = '{16'hFFFE, 16'hFFFC, 16'hFFFA, 16'hFFFE};
    @(posedge clk);
    debug_firmware_mode <= 1'b1;
    vchk('0, 6'b000100, 16'hFFF8);
    @(posedge clk);
    debug_firmware_mode <= 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk);
      reset_source <= 2'(s);
      ask(1'b1, a);
      check(a, ex[s]);
    end
  endtask

  // Wake-up from low power
  task automatic t_wake;
    logic [7:0] d;
    req(57'h8, 6'b000010);
    lowpower_mode <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check({15'h0, wake}, 16'h0000);
    req(57'h8, 6'b000000);
    repeat (3) @(posedge clk);
    #1 check({15'h0, wake}, 16'h0001);
    req('0, 6'b100011);
    repeat (3) @(posedge clk);
    #1 check({15'h0, wake}, 16'h0001);
    // Status: last grant reset (6), wake set, nothing servable
    rd(REG_STATUS, d);
    check({8'h00, d}, 16'h000E);
    req('0, 6'b000000);
    lowpower_mode <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Mid-run reset must drop the programmed base back to all ones
  task automatic t_rerst;
    logic [7:0] d;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 check(vec_addr, 16'hFFFE);
    rd(REG_VBASE, d);
    check({8'h00, d}, 16'h00FF);
    vchk('0, 6'h00, 16'hFF80);
  endtask

  // Main sequence
  initial
  begin
    failures = 0;
    checks_done = 0;
    rst = 1'b1;
    {reg_wr, reg_rd, ask_vec, ask_rst} = 4'h0;
    {reg_addr, reg_wdata, reset_source} = '0;
    {irq_req, xirq_req, software_exception, debug_req, trap_req} = '0;
    {core_imask, core_xmask, debug_firmware_mode, lowpower_mode} = 4'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 t_reset();
    t_base();
    t_prio();
    t_fixed();
    t_wake();
    t_rerst();
    report_and_stop();
  end
endmodule // testbench
